// ### ctmc_device.sv
// Transceiver operating-mode controller (device end).
// Assumes pins from the host are asynchronous; supply monitors are levels.
`timescale 1ns/1ns
`include "ctmc_defines.svh"
module ctmc_device (
   input  wire logic             clk_sys,
   input  wire logic             rst_n,
   ctmc_if.device                pins,
   input  wire logic             bus_rx,
   input  wire logic             wake_event,
   input  wire logic             core_uv,
   input  wire logic             io_uv,
   input  wire logic             battery_undervoltage,
   output ctmc_pkg::ctmc_mode_t  mode,
   output logic                  driver_en,
   output logic                  receiver_en,
   output logic                  supply_enable_output,
   output logic                  supply_enable_oe,
   output logic                  inhibit_mask_r,
   output logic                  wake_request_flag
);
   import ctmc_pkg::*;
   localparam logic [`CTMC_CNT_W-1:0] UV_CYC  = `CTMC_CNT_W'(`CTMC_UV_TIMEOUT_CYC);
   localparam logic [`CTMC_CNT_W-1:0] GTS_CYC = `CTMC_CNT_W'(`CTMC_GTS_DELAY_CYC);
   localparam logic [15:0]            SWE_CYC = 16'(`CTMC_SWE_TIMEOUT_US);
   // ****************************************
   // Synchronisers
   // ****************************************
   logic [2:0] s1_r, s2_r, asy;
   logic       sel_d_r, stb_d_r;
   logic [2:0] sup1_r, sup2_r;
   logic [1:0] ev1_r, ev2_r;
   assign asy = {pins.mode_select, pins.standby_control_pin, pins.inhibit_mask_input};
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         s1_r   <= 3'h0;
         s2_r   <= 3'h0;
         sup1_r <= 3'h7;
         sup2_r <= 3'h7;
         ev1_r  <= 2'h2;
         ev2_r  <= 2'h2;
      end else begin
         s1_r   <= asy;
         s2_r   <= s1_r;
         sup1_r <= {core_uv, io_uv, battery_undervoltage};
         sup2_r <= sup1_r;
         ev1_r  <= {bus_rx, wake_event};
         ev2_r  <= ev1_r;
      end
   end
   logic bus_s, wake_s;
   assign {bus_s, wake_s} = ev2_r;
   logic sel, stb, msk, c_uv, i_uv, b_uv;
   assign {sel, stb, msk}    = s2_r;
   assign {c_uv, i_uv, b_uv} = sup2_r;
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         sel_d_r <= 1'b0;
         stb_d_r <= 1'b0;
      end else begin
         sel_d_r <= sel;
         stb_d_r <= stb;
      end
   end
   logic sel_rise, sel_fall, stb_rise;
   assign sel_rise = sel & ~sel_d_r;
   assign sel_fall = ~sel & sel_d_r;
   assign stb_rise = stb & ~stb_d_r;
   // ****************************************
   // Undervoltage timers
   // ****************************************
   logic                  c_arm_r, i_arm_r;
   logic [`CTMC_CNT_W-1:0] c_cnt_r, i_cnt_r;
   logic                  uv_expire;
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         c_arm_r <= 1'b0;
         i_arm_r <= 1'b0;
      end else begin
         if (!c_uv) c_arm_r <= 1'b1;
         if (!i_uv) i_arm_r <= 1'b1;
      end
   end
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         c_cnt_r <= '0;
         i_cnt_r <= '0;
      end else begin
         c_cnt_r <= (c_arm_r && c_uv && c_cnt_r != UV_CYC) ? c_cnt_r + 1'b1 :
                    (c_uv ? c_cnt_r : '0);
         i_cnt_r <= (i_arm_r && i_uv && i_cnt_r != UV_CYC) ? i_cnt_r + 1'b1 :
                    (i_uv ? i_cnt_r : '0);
      end
   end
   assign uv_expire = (c_cnt_r == UV_CYC) || (i_cnt_r == UV_CYC);
   // ****************************************
   // Failsafe timer (microsecond prescaled)
   // ****************************************
   logic [3:0]  pre_r;
   logic [15:0] swe_r;
   logic        swe_run_r, swe_exp;
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         pre_r <= 4'h0;
      end else begin
         pre_r <= (pre_r == 4'h9) ? 4'h0 : pre_r + 4'h1;
      end
   end
   assign swe_exp = swe_run_r && (swe_r == SWE_CYC);
   // ****************************************
   // Mode machine
   // ****************************************
   ctmc_mode_t mode_r;
   logic       swe_sleep_r, armed_r, gts_done;
   logic [`CTMC_CNT_W-1:0] gts_r;
   assign gts_done = (gts_r == GTS_CYC);
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         mode_r      <= CTMC_STANDBY;
         swe_sleep_r <= 1'b0;
         armed_r     <= 1'b0;
      end else if (b_uv) begin
         mode_r <= CTMC_OFF;
      end else begin
         unique case (mode_r)
            CTMC_OFF: mode_r <= CTMC_STANDBY;
            CTMC_NORMAL, CTMC_SILENT, CTMC_STANDBY: begin
               if (uv_expire) begin
                  mode_r      <= CTMC_SLEEP;
                  swe_sleep_r <= 1'b0;
               end else if (swe_exp) begin
                  mode_r      <= CTMC_SLEEP;
                  swe_sleep_r <= 1'b1;
                  armed_r     <= ~stb;
               end else if (i_uv) begin
                  mode_r <= CTMC_STANDBY;
               end else if (stb) begin
                  mode_r <= sel ? CTMC_NORMAL : CTMC_SILENT;
               end else begin
                  mode_r <= sel ? CTMC_GTS : CTMC_STANDBY;
               end
            end
            CTMC_GTS: begin
               if (stb) mode_r <= sel ? CTMC_NORMAL : CTMC_SILENT;
               else if (!sel) mode_r <= CTMC_STANDBY;
               else if (gts_done) begin
                  mode_r      <= CTMC_SLEEP;
                  swe_sleep_r <= 1'b0;
               end
            end
            CTMC_SLEEP: begin
               if (wake_s) begin
                  mode_r <= CTMC_STANDBY;
               end else if (!i_uv) begin
                  if (!swe_sleep_r) begin
                     if (stb_rise) mode_r <= sel ? CTMC_NORMAL : CTMC_SILENT;
                  end else begin
                     if (!stb && (sel_rise || sel_fall)) armed_r <= 1'b1;
                     if (stb && stb_d_r && armed_r && sel_rise) mode_r <= CTMC_NORMAL;
                     if (stb && stb_d_r && armed_r && sel_fall) mode_r <= CTMC_SILENT;
                  end
               end
            end
            default: mode_r <= CTMC_OFF;
         endcase
      end
   end
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         gts_r <= '0;
      end else begin
         gts_r <= (mode_r == CTMC_GTS && !gts_done) ? gts_r + 1'b1 :
                  (mode_r == CTMC_GTS ? gts_r : '0);
      end
   end
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         swe_run_r <= 1'b0;
         swe_r     <= 16'h0000;
      end else if (mode_r == CTMC_NORMAL || mode_r == CTMC_SLEEP || mode_r == CTMC_OFF) begin
         swe_run_r <= 1'b0;
         swe_r     <= 16'h0000;
      end else if (mode_r == CTMC_STANDBY) begin
         swe_run_r <= 1'b1;
         if (pre_r == 4'h9 && swe_r != SWE_CYC) swe_r <= swe_r + 16'h0001;
      end else if (swe_run_r && pre_r == 4'h9 && swe_r != SWE_CYC) begin
         swe_r <= swe_r + 16'h0001;
      end
   end
   // ****************************************
   // Inhibit mask and outputs
   // ****************************************
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         inhibit_mask_r <= 1'b0;
      end else if (b_uv) begin
         inhibit_mask_r <= 1'b0;
      end else if (mode_r == CTMC_SILENT) begin
         inhibit_mask_r <= msk;
      end
   end
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         wake_request_flag <= 1'b0;
      end else if (mode_r == CTMC_NORMAL || b_uv) begin
         wake_request_flag <= 1'b0;
      end else if (wake_s) begin
         wake_request_flag <= 1'b1;
      end
   end
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         mode                 <= CTMC_STANDBY;
         driver_en            <= 1'b0;
         receiver_en          <= 1'b0;
         supply_enable_output <= 1'b0;
         supply_enable_oe     <= 1'b0;
         pins.rxd             <= 1'b1;
         pins.rxd_oe          <= 1'b0;
      end else begin
         mode                 <= mode_r;
         driver_en            <= (mode_r == CTMC_NORMAL);
         receiver_en          <= (mode_r == CTMC_NORMAL || mode_r == CTMC_SILENT);
         supply_enable_output <= ~inhibit_mask_r;
         supply_enable_oe     <= ~(mode_r == CTMC_SLEEP || mode_r == CTMC_OFF);
         pins.rxd_oe          <= ~(mode_r == CTMC_OFF || i_uv);
         pins.rxd             <= (mode_r == CTMC_NORMAL || mode_r == CTMC_SILENT) ? bus_s :
                                 ~wake_request_flag;
      end
   end
endmodule // ctmc_device

// ### ctmc_defines.svh
// Timing counts and counter width shared by both ends of the mode-control link.
// Assumes a 10 MHz system clock on both ends.
`ifndef CTMC_DEFINES_SVH
`define CTMC_DEFINES_SVH
// ****************************************
// Timing
// ****************************************
`define CTMC_CLK_NS            100
`define CTMC_UV_TIMEOUT_US     350
`define CTMC_UV_TIMEOUT_CYC    ((`CTMC_UV_TIMEOUT_US * 1000) / `CTMC_CLK_NS)
`define CTMC_SWE_TIMEOUT_MS    4
`define CTMC_SWE_TIMEOUT_CYC   ((`CTMC_SWE_TIMEOUT_MS * 1000000) / `CTMC_CLK_NS)
`define CTMC_SWE_TIMEOUT_US    (`CTMC_SWE_TIMEOUT_MS * 1000)
`define CTMC_GTS_DELAY_US      20
`define CTMC_GTS_DELAY_CYC     ((`CTMC_GTS_DELAY_US * 1000) / `CTMC_CLK_NS)
`define CTMC_MODE_HOLD_US      20
`define CTMC_MODE_HOLD_CYC     (((`CTMC_MODE_HOLD_US * 1000) + `CTMC_CLK_NS - 1) / `CTMC_CLK_NS)
`define CTMC_CNT_W             16
`endif

// ### ctmc_pkg.sv
// Types shared by both ends of the transceiver mode controller.
// Assumes ctmc_defines.svh sits in the same folder.
package ctmc_pkg;
   // ****************************************
   // Modes
   // ****************************************
   typedef enum logic [2:0] {
      CTMC_NORMAL  = 3'h0,
      CTMC_SILENT  = 3'h1,
      CTMC_STANDBY = 3'h2,
      CTMC_GTS     = 3'h3,
      CTMC_SLEEP   = 3'h4,
      CTMC_OFF     = 3'h5
   } ctmc_mode_t;
   // Host requests
   typedef enum logic [2:0] {
      CTMC_REQ_NORMAL  = 3'h0,
      CTMC_REQ_SILENT  = 3'h1,
      CTMC_REQ_STANDBY = 3'h2,
      CTMC_REQ_SLEEP   = 3'h3,
      CTMC_REQ_SWE_NRM = 3'h4,
      CTMC_REQ_SWE_SIL = 3'h5
   } ctmc_req_t;
endpackage

// ### ctmc_if.sv
// Pin bundle between host controller and transceiver mode controller.
// Assumes both ends share clk_sys; pins are plain levels.
`timescale 1ns/1ns
interface ctmc_if;
   logic mode_select;
   logic standby_control_pin;
   logic inhibit_mask_input;
   logic rxd;
   logic rxd_oe;
   modport device (input mode_select, input standby_control_pin, input inhibit_mask_input,
                   output rxd, output rxd_oe);
   modport host   (output mode_select, output standby_control_pin,
                   output inhibit_mask_input, input rxd, input rxd_oe);
endinterface

// ### ctmc_host.sv
// Host-side mode pin sequencer for the transceiver mode controller.
// Assumes requests arrive on clk_sys; rxd is synchronised here.
`timescale 1ns/1ns
`include "ctmc_defines.svh"
module ctmc_host (
   input  wire logic            clk_sys,
   input  wire logic            rst_n,
   ctmc_if.host                 pins,
   input  wire logic            req_valid,
   input  ctmc_pkg::ctmc_req_t  req,
   input  wire logic            mask_value,
   output logic                 busy,
   output logic                 wake_seen
);
   import ctmc_pkg::*;
   localparam logic [`CTMC_CNT_W-1:0] HOLD = `CTMC_CNT_W'(`CTMC_MODE_HOLD_CYC);
   typedef enum logic [1:0] {
      CTMC_H_IDLE = 2'h0,
      CTMC_H_LOW  = 2'h1,
      CTMC_H_HIGH = 2'h2
   } ctmc_hst_t;
   ctmc_hst_t st_r;
   logic [`CTMC_CNT_W-1:0] cnt_r;
   logic to_normal_r, rx1_r, rx2_r;
   // ****************************************
   // Pin sequencer
   // ****************************************
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         st_r                     <= CTMC_H_IDLE;
         cnt_r                    <= '0;
         to_normal_r              <= 1'b0;
         busy                     <= 1'b0;
         pins.mode_select         <= 1'b0;
         pins.standby_control_pin <= 1'b0;
         pins.inhibit_mask_input  <= 1'b0;
      end else begin
         pins.inhibit_mask_input <= mask_value;
         unique case (st_r)
            CTMC_H_IDLE: if (req_valid) begin
               unique case (req)
                  CTMC_REQ_NORMAL:  {pins.standby_control_pin, pins.mode_select} <= 2'b11;
                  CTMC_REQ_SILENT:  {pins.standby_control_pin, pins.mode_select} <= 2'b10;
                  CTMC_REQ_STANDBY: {pins.standby_control_pin, pins.mode_select} <= 2'b00;
                  CTMC_REQ_SLEEP:   {pins.standby_control_pin, pins.mode_select} <= 2'b01;
                  default: begin
                     pins.standby_control_pin <= 1'b0;
                     pins.mode_select         <= ~pins.mode_select;
                     to_normal_r              <= (req == CTMC_REQ_SWE_NRM);
                     cnt_r                    <= '0;
                     busy                     <= 1'b1;
                     st_r                     <= CTMC_H_LOW;
                  end
               endcase
            end
            CTMC_H_LOW: begin
               if (cnt_r == HOLD) begin
                  pins.standby_control_pin <= 1'b1;
                  pins.mode_select         <= ~to_normal_r;
                  st_r                     <= CTMC_H_HIGH;
               end else begin
                  cnt_r <= cnt_r + 1'b1;
               end
            end
            CTMC_H_HIGH: begin
               pins.mode_select <= to_normal_r;
               busy             <= 1'b0;
               st_r             <= CTMC_H_IDLE;
            end
            default: st_r <= CTMC_H_IDLE;
         endcase
      end
   end
   // ****************************************
   // Wake indication
   // ****************************************
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rx1_r     <= 1'b1;
         rx2_r     <= 1'b1;
         wake_seen <= 1'b0;
      end else begin
         rx1_r     <= pins.rxd;
         rx2_r     <= rx1_r;
         wake_seen <= ~rx2_r;
      end
   end
endmodule // ctmc_host

// ### ctmc_sva.sv
// Concurrent checks on the mode controller pins and device state.
// Assumes it is instantiated in the bench beside the ctmc_if bundle.
`timescale 1ns/1ns
`include "ctmc_defines.svh"
module ctmc_sva (
   input wire logic            clk_sys,
   input wire logic            rst_n,
   input wire logic            rxd,
   input wire logic            rxd_oe,
   input wire logic            bus_rx,
   input wire logic            core_uv,
   input wire logic            io_uv,
   input wire logic            battery_undervoltage,
   input ctmc_pkg::ctmc_mode_t mode,
   input wire logic            driver_en,
   input wire logic            receiver_en,
   input wire logic            supply_enable_oe,
   input wire logic            inhibit_mask_r,
   input wire logic            wake_request_flag
);
   import ctmc_pkg::*;
   logic [15:0] gts_cnt_r;
   logic [15:0] uv_cnt_r;
   logic [3:0]  bat_calm_r;
   // ****************************************
   // Helper counters
   // ****************************************
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         gts_cnt_r <= 16'h0000;
      end else begin
         gts_cnt_r <= (mode == CTMC_GTS) ? gts_cnt_r + 16'h0001 : 16'h0000;
      end
   end
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         uv_cnt_r   <= 16'h0000;
         bat_calm_r <= 4'h0;
      end else begin
         uv_cnt_r   <= (core_uv || io_uv) ? uv_cnt_r + 16'h0001 : 16'h0000;
         bat_calm_r <= battery_undervoltage ? 4'h0 : bat_calm_r + {3'h0, bat_calm_r != 4'hf};
      end
   end
   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   normal_drive_a:
      assert property (mode == CTMC_NORMAL && $past(mode) == CTMC_NORMAL
         |-> driver_en && receiver_en) else $error("normal mode lacks driver or receiver");
   silent_listen_a:
      assert property (mode == CTMC_SILENT && $past(mode) == CTMC_SILENT
         |-> !driver_en && receiver_en) else $error("silent mode output enables wrong");
   rx_mirror_a:
      assert property ((mode == CTMC_NORMAL && $stable(bus_rx))[*4]
         |-> rxd == bus_rx && rxd_oe) else $error("receive output does not follow bus");
   wake_low_a:
      assert property ((mode == CTMC_STANDBY && wake_request_flag)[*3]
         |-> !rxd && rxd_oe) else $error("pending wake not shown low on rxd");
   gts_wait_a:
      assert property (mode == CTMC_SLEEP && $past(mode) == CTMC_GTS
         |-> gts_cnt_r >= `CTMC_GTS_DELAY_CYC - 2) else $error("sleep entered too early");
   sleep_inh_off_a:
      assert property (mode == CTMC_SLEEP && $past(mode) == CTMC_SLEEP
         |-> !supply_enable_oe) else $error("supply enable driven in sleep");
   off_release_a:
      assert property (mode == CTMC_OFF && $past(mode) == CTMC_OFF
         |-> !(driver_en || receiver_en || rxd_oe || supply_enable_oe || inhibit_mask_r))
      else $error("protected state outputs not released");
   mask_hold_a:
      assert property (bat_calm_r > 4'h4 && mode != CTMC_SILENT && $past(mode) != CTMC_SILENT
         |-> $stable(inhibit_mask_r)) else $error("mask latch changed outside silent");
   uv_limit_a:
      assert property (uv_cnt_r > `CTMC_UV_TIMEOUT_CYC + 16
         |-> mode inside {CTMC_SLEEP, CTMC_OFF}) else $error("undervoltage timeout missed");
endmodule // ctmc_sva

// ### ctmc_bench.sv
// Bench joining host and device ends over ctmc_if.
// Assumes the design files and ctmc_sva.sv are compiled first.
`timescale 1ns/1ns
`include "ctmc_defines.svh"
module ctmc_bench;
   import ctmc_pkg::*;
   logic       clk_sys              = 1'b0;
   logic       rst_n                = 1'b0;
   logic       req_valid            = 1'b0;
   ctmc_req_t  req                  = CTMC_REQ_STANDBY;
   logic       mask_value           = 1'b0;
   logic       bus_rx               = 1'b1;
   logic       wake_event           = 1'b0;
   logic       core_uv              = 1'b0;
   logic       io_uv                = 1'b0;
   logic       battery_undervoltage = 1'b0;
   ctmc_mode_t mode;
   logic       driver_en, receiver_en, supply_enable_output, supply_enable_oe;
   logic       inhibit_mask_r, wake_request_flag, busy, wake_seen;
   int         err_count = 0;
   int         checked   = 0;
   ctmc_if pins_if ();
   ctmc_host i_ctmc_host (.clk_sys, .rst_n, .pins(pins_if.host), .req_valid, .req,
      .mask_value, .busy, .wake_seen);
   ctmc_device i_ctmc_device (.clk_sys, .rst_n, .pins(pins_if.device), .bus_rx, .wake_event,
      .core_uv, .io_uv, .battery_undervoltage, .mode, .driver_en, .receiver_en,
      .supply_enable_output, .supply_enable_oe, .inhibit_mask_r, .wake_request_flag);
   ctmc_sva i_ctmc_sva (.clk_sys, .rst_n, .rxd(pins_if.rxd), .rxd_oe(pins_if.rxd_oe), .bus_rx,
      .core_uv, .io_uv, .battery_undervoltage, .mode, .driver_en, .receiver_en,
      .supply_enable_oe, .inhibit_mask_r, .wake_request_flag);
   // ****************************************
   // Tasks
   // ****************************************
   task automatic check(input logic [2:0] seen, input logic [2:0] exp);
      checked++;
      if (seen !== exp) begin
         err_count++;
         $display("CHECK FAILED at %0t: saw %b expected %b", $time, seen, exp);
      end
   endtask
   task automatic cycles(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   task automatic send(input ctmc_req_t r);
      int k;
      k = 0;
      req       <= r;
      req_valid <= 1'b1;
      @(posedge clk_sys);
      req_valid <= 1'b0;
      @(posedge clk_sys);
      while (busy !== 1'b0 && k < 1000) begin
         @(posedge clk_sys);
         k++;
      end
      check({2'b00, busy}, 3'b000);
      cycles(10);
   endtask
   task automatic complete_run;
      $display("Comparisons %0d, mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // ****************************************
   // Stimulus
   // ****************************************
   initial begin
      forever #50 clk_sys = ~clk_sys;
   end
   initial begin
      cycles(95000);
      err_count++;
      complete_run();
   end
   initial begin
      cycles(6);
      rst_n <= 1'b1;
      cycles(10);
      check(mode, CTMC_STANDBY);
      wake_event <= 1'b1;
      cycles(1);
      wake_event <= 1'b0;
      cycles(10);
      check({wake_request_flag, pins_if.rxd, wake_seen}, 3'b101);
      send(CTMC_REQ_NORMAL);
      bus_rx <= 1'b0;
      cycles(5);
      check({driver_en, receiver_en, pins_if.rxd}, 3'b110);
      bus_rx <= 1'b1;
      send(CTMC_REQ_SILENT);
      mask_value <= 1'b1;
      cycles(10);
      check({driver_en, receiver_en, inhibit_mask_r}, 3'b011);
      check({supply_enable_oe, supply_enable_output, 1'b0}, 3'b100);
      send(CTMC_REQ_NORMAL);
      mask_value <= 1'b0;
      cycles(10);
      check({mode == CTMC_NORMAL, 1'b0, inhibit_mask_r}, 3'b101);
      for (int i = 0; i < 2; i++) begin
         send(CTMC_REQ_SLEEP);
         check(mode, CTMC_GTS);
         cycles(`CTMC_GTS_DELAY_CYC);
         check(mode, CTMC_SLEEP);
         check({supply_enable_oe, driver_en, receiver_en}, 3'b000);
         io_uv <= 1'b1;
         send(i ? CTMC_REQ_SILENT : CTMC_REQ_NORMAL);
         check(mode, CTMC_SLEEP);
         send(CTMC_REQ_STANDBY);
         io_uv <= 1'b0;
         cycles(10);
         send(i ? CTMC_REQ_SILENT : CTMC_REQ_NORMAL);
         check(mode, i ? CTMC_SILENT : CTMC_NORMAL);
      end
      core_uv <= 1'b1;
      cycles(`CTMC_UV_TIMEOUT_CYC - 100);
      check(mode, CTMC_SILENT);
      cycles(120);
      check(mode, CTMC_SLEEP);
      core_uv <= 1'b0;
      send(CTMC_REQ_STANDBY);
      send(CTMC_REQ_NORMAL);
      check(mode, CTMC_NORMAL);
      send(CTMC_REQ_STANDBY);
      cycles(`CTMC_SWE_TIMEOUT_CYC - 500);
      check(mode, CTMC_STANDBY);
      cycles(1000);
      check(mode, CTMC_SLEEP);
      send(CTMC_REQ_SWE_NRM);
      check(mode, CTMC_NORMAL);
      send(CTMC_REQ_STANDBY);
      cycles(`CTMC_SWE_TIMEOUT_CYC / 2);
      send(CTMC_REQ_SILENT);
      cycles(`CTMC_SWE_TIMEOUT_CYC / 2 - 500);
      check(mode, CTMC_SILENT);
      cycles(1000);
      check(mode, CTMC_SLEEP);
      send(CTMC_REQ_SWE_SIL);
      check(mode, CTMC_SILENT);
      mask_value <= 1'b1;
      cycles(10);
      check({2'b00, inhibit_mask_r}, 3'b001);
      battery_undervoltage <= 1'b1;
      cycles(10);
      check(mode, CTMC_OFF);
      check({driver_en, receiver_en, pins_if.rxd_oe}, 3'b000);
      check({1'b0, supply_enable_oe, inhibit_mask_r}, 3'b000);
      send(CTMC_REQ_STANDBY);
      battery_undervoltage <= 1'b0;
      cycles(10);
      check(mode, CTMC_STANDBY);
      check({2'b00, inhibit_mask_r}, 3'b000);
      complete_run();
   end
endmodule // ctmc_bench
